// File: core/utd_pkg.sv
// Purpose: Constants and types for the USB termination state decoder.
// Assumes: One clock domain, synchronous active-high reset.
// Notes: Register offsets are byte addresses on the plain register port.
//
// Summary of operation
// - D+ pull-up enable output switches in the 1.5 kOhm pull-up.
// - D+ pull-down enable output switches in the 15 kOhm pull-down.
// - D- pull-down enable output switches in the 15 kOhm pull-down.
// - High-speed termination enable switches in both 45 Ohm terminations.
// - Operating mode 01b forces all four resistor enables off.
// - Otherwise termination on only when speed select 00b and term 0.
// - Otherwise pull-up on only when term select 1 and D+ pull-down bit 0.
// - Otherwise each pull-down enable follows its own pull-down bit.
// - In UART mode the interface clock runs when keep-alive is 1.
// - In UART mode the clock stops when keep-alive is 0, its default.
// - Stop or a chip select toggle ends UART mode, back to sync mode.
package utd_pkg;

    // ********************************
    // Register port
    // ********************************
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 8;
    localparam logic [7:0] CTRL_ADDR = 8'h00;
    localparam logic [7:0] UART_ADDR = 8'h01;
    localparam logic [7:0] STAT_ADDR = 8'h02;

    // ********************************
    // Field positions
    // ********************************
    localparam int unsigned CTRL_XCVR_LSB = 0;
    localparam int unsigned CTRL_TERM_BIT = 2;
    localparam int unsigned CTRL_OPERATING_MODE_FIELD_LSB = 3;
    localparam int unsigned CTRL_DPPD_BIT = 5;
    localparam int unsigned CTRL_DMPD_BIT = 6;
    localparam int unsigned UART_KEEP_BIT = 0;
    localparam int unsigned UART_ENTER_BIT = 1;
    localparam int unsigned UART_ACTIVE_BIT = 2;
    localparam int unsigned STAT_PU_BIT = 0;
    localparam int unsigned STAT_DPPD_BIT = 1;
    localparam int unsigned STAT_DMPD_BIT = 2;
    localparam int unsigned STAT_HS_BIT = 3;
    localparam int unsigned STAT_CLK_BIT = 4;

    // ********************************
    // Encodings and reset values
    // ********************************
    localparam logic [1:0] XCVR_HS = 2'h0;
    localparam logic [1:0] XCVR_FS = 2'h1;
    localparam logic [1:0] OPERATING_MODE_FIELD_NORMAL = 2'h0;
    localparam logic [1:0] OPERATING_MODE_FIELD_NONDRIVE = 2'h1;
    localparam logic [1:0] XCVR_RST = XCVR_FS;
    localparam logic TERM_RST = 1'h0;
    localparam logic [1:0] OPERATING_MODE_FIELD_RST = OPERATING_MODE_FIELD_NORMAL;
    localparam logic PD_RST = 1'h1;
    localparam logic KEEP_RST = 1'h0;
    localparam logic CS_RST = 1'h1;

    typedef enum logic {BUS_SYNC, BUS_UART} utd_bus_state_t;

endpackage

// File: core/utd_term_if.sv
// Purpose: Carries control bits to the decoder and enables back.
// Assumes: Purely combinational path inside one clock domain.
// Notes: Owner drives controls, decoder drives enables.
`timescale 1ns/10ps
interface utd_term_if;
    logic [1:0] xcvr;
    logic term;
    logic [1:0] operating_mode_field;
    logic dp_pd;
    logic dm_pd;
    logic pu_en;
    logic dppd_en;
    logic dmpd_en;
    logic hs_en;

    modport ctl (
        output xcvr, term, operating_mode_field, dp_pd, dm_pd,
        input pu_en, dppd_en, dmpd_en, hs_en
    );
    modport dec (
        input xcvr, term, operating_mode_field, dp_pd, dm_pd,
        output pu_en, dppd_en, dmpd_en, hs_en
    );
endinterface

// File: core/utd_term_decode.sv
// Purpose: Maps transceiver control bits to the four resistor enables.
// Assumes: Inputs are stable register outputs.
// Notes: Combinational; the owner registers the results.
`timescale 1ns/10ps
module utd_term_decode
    import utd_pkg::*;
(
    // Controls in, enables out
    utd_term_if.dec tif
);

    // ********************************
    // Decode
    // ********************************
    // Non-driving mode dominates every other setting
    wire nondrive = (tif.operating_mode_field == OPERATING_MODE_FIELD_NONDRIVE);
    wire hs_sel = (tif.xcvr == XCVR_HS) && !tif.term;
    // Pull-up only when the line is not also pulled down (host side)
    wire pu_sel = tif.term && !tif.dp_pd;

    assign tif.hs_en = !nondrive && hs_sel;
    assign tif.pu_en = !nondrive && pu_sel;
    assign tif.dppd_en = !nondrive && tif.dp_pd;
    assign tif.dmpd_en = !nondrive && tif.dm_pd;

endmodule

// File: core/utd_top.sv
// Purpose: Transceiver termination control with UART clock handling.
// Assumes: Link writes control bits over the register port on CLK_SYS.
// Notes: Resistor enables lag a control write by two clocks.
`timescale 1ns/10ps
module utd_top
    import utd_pkg::*;
(
    // Clock and reset
    input wire logic CLK_SYS,
    input wire logic RESET,
    // Register port
    input wire logic [ADDR_W-1:0] REG_ADDR,
    input wire logic [DATA_W-1:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [DATA_W-1:0] REG_RDATA,
    // Link control pins
    input wire logic ULPI_STP,
    input wire logic CHIP_SELECT_N,
    // Resistor enables
    output logic DPLUS_PULLUP_ENABLE,
    output logic DPLUS_PULLDOWN_ENABLE,
    output logic DMINUS_PULLDOWN_ENABLE,
    output logic HIGHSPEED_TERMINATION_ENABLE,
    // Interface clock and bus mode
    output logic INTERFACE_CLOCK_RUN,
    output logic UART_MODE_ACTIVE
);

    // ********************************
    // Control register state
    // ********************************
    logic [1:0] transceiver_speed_select_q;
    logic termination_select_q;
    logic [1:0] operating_mode_field_q;
    logic dplus_pulldown_bit_q;
    logic dminus_pulldown_bit_q;
    logic clock_keepalive_bit_q;
    logic [1:0] transceiver_speed_select_d;
    logic termination_select_d;
    logic [1:0] operating_mode_field_d;
    logic dplus_pulldown_bit_d;
    logic dminus_pulldown_bit_d;
    logic clock_keepalive_bit_d;

    utd_bus_state_t state_q;
    utd_bus_state_t state_d;
    logic cs_q;
    logic clk_run_q;
    logic clk_run_d;
    logic [DATA_W-1:0] rdata_q;

    logic pu_q;
    logic dppd_q;
    logic dmpd_q;
    logic hs_q;

    // ********************************
    // Register decode
    // ********************************
    wire ctrl_wr = REG_WR && (REG_ADDR == CTRL_ADDR);
    wire uart_wr = REG_WR && (REG_ADDR == UART_ADDR);
    wire enter_req = uart_wr && REG_WDATA[UART_ENTER_BIT];
    wire cs_toggle = (CHIP_SELECT_N != cs_q);
    // Exit request from the link, either by stop or by chip select
    wire exit_req = ULPI_STP || cs_toggle;

    // The link alone chooses the signalling state
    assign transceiver_speed_select_d = ctrl_wr ?
        REG_WDATA[CTRL_XCVR_LSB +: 2] : transceiver_speed_select_q;
    assign termination_select_d = ctrl_wr ?
        REG_WDATA[CTRL_TERM_BIT] : termination_select_q;
    assign operating_mode_field_d = ctrl_wr ?
        REG_WDATA[CTRL_OPERATING_MODE_FIELD_LSB +: 2] : operating_mode_field_q;
    assign dplus_pulldown_bit_d = ctrl_wr ?
        REG_WDATA[CTRL_DPPD_BIT] : dplus_pulldown_bit_q;
    assign dminus_pulldown_bit_d = ctrl_wr ?
        REG_WDATA[CTRL_DMPD_BIT] : dminus_pulldown_bit_q;
    assign clock_keepalive_bit_d = uart_wr ?
        REG_WDATA[UART_KEEP_BIT] : clock_keepalive_bit_q;

    // ********************************
    // Read mux
    // ********************************
    wire [DATA_W-1:0] ctrl_rd = {
        1'b0,
        dminus_pulldown_bit_q,
        dplus_pulldown_bit_q,
        operating_mode_field_q,
        termination_select_q,
        transceiver_speed_select_q
    };
    wire [DATA_W-1:0] uart_rd = {
        5'h00,
        (state_q == BUS_UART),
        1'b0,
        clock_keepalive_bit_q
    };
    wire [DATA_W-1:0] stat_rd = {
        3'h0,
        clk_run_q,
        hs_q,
        dmpd_q,
        dppd_q,
        pu_q
    };
    // Unmapped addresses read as zero
    wire [DATA_W-1:0] rd_mux =
        (REG_ADDR == CTRL_ADDR) ? ctrl_rd :
        (REG_ADDR == UART_ADDR) ? uart_rd :
        (REG_ADDR == STAT_ADDR) ? stat_rd : 8'h00;
    wire [DATA_W-1:0] rdata_d = REG_RD ? rd_mux : 8'h00;

    // ********************************
    // Bus mode machine
    // ********************************
    // An exit in the same cycle as an entry wins, so a stuck stop
    // line can never leave the bus parked in UART mode.
    always_comb begin
        state_d = state_q;
        case (state_q)
            BUS_SYNC: begin
                if (enter_req && !exit_req) begin
                    state_d = BUS_UART;
                end
            end
            BUS_UART: begin
                if (exit_req) begin
                    state_d = BUS_SYNC;
                end
            end
            default: begin
                state_d = BUS_SYNC;
            end
        endcase
    end

    // Clock runs in sync mode, and in UART mode only if kept alive
    assign clk_run_d = (state_d == BUS_SYNC) ||
        clock_keepalive_bit_d;

    // ********************************
    // Decoder
    // ********************************
    utd_term_if tif ();

    assign tif.xcvr = transceiver_speed_select_q;
    assign tif.term = termination_select_q;
    assign tif.operating_mode_field = operating_mode_field_q;
    assign tif.dp_pd = dplus_pulldown_bit_q;
    assign tif.dm_pd = dminus_pulldown_bit_q;

    utd_term_decode u_decode (
        .tif(tif)
    );

    // ********************************
    // Registers
    // ********************************
    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            transceiver_speed_select_q <= XCVR_RST;
            termination_select_q <= TERM_RST;
            operating_mode_field_q <= OPERATING_MODE_FIELD_RST;
            dplus_pulldown_bit_q <= PD_RST;
            dminus_pulldown_bit_q <= PD_RST;
            clock_keepalive_bit_q <= KEEP_RST;
        end else begin
            transceiver_speed_select_q <= transceiver_speed_select_d;
            termination_select_q <= termination_select_d;
            operating_mode_field_q <= operating_mode_field_d;
            dplus_pulldown_bit_q <= dplus_pulldown_bit_d;
            dminus_pulldown_bit_q <= dminus_pulldown_bit_d;
            clock_keepalive_bit_q <= clock_keepalive_bit_d;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            state_q <= BUS_SYNC;
            cs_q <= CS_RST;
            clk_run_q <= 1'b1;
            rdata_q <= 8'h00;
        end else begin
            state_q <= state_d;
            cs_q <= CHIP_SELECT_N;
            clk_run_q <= clk_run_d;
            rdata_q <= rdata_d;
        end
    end

    // Reset values match the power-up resistor state
    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            pu_q <= 1'b0;
            dppd_q <= PD_RST;
            dmpd_q <= PD_RST;
            hs_q <= 1'b0;
        end else begin
            pu_q <= tif.pu_en;
            dppd_q <= tif.dppd_en;
            dmpd_q <= tif.dmpd_en;
            hs_q <= tif.hs_en;
        end
    end

    // ********************************
    // Outputs
    // ********************************
    assign REG_RDATA = rdata_q;
    assign DPLUS_PULLUP_ENABLE = pu_q;
    assign DPLUS_PULLDOWN_ENABLE = dppd_q;
    assign DMINUS_PULLDOWN_ENABLE = dmpd_q;
    assign HIGHSPEED_TERMINATION_ENABLE = hs_q;
    assign INTERFACE_CLOCK_RUN = clk_run_q;
    assign UART_MODE_ACTIVE = (state_q == BUS_UART);

    // ********************************
    // Assertions
    // ********************************
    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (RESET);

    sequence s_ctrl_write;
        REG_WR && (REG_ADDR == CTRL_ADDR);
    endsequence

    sequence s_in_uart;
        state_q == BUS_UART;
    endsequence

    sequence s_exit_seen;
        s_in_uart ##0 (ULPI_STP || cs_toggle);
    endsequence

    a_nondrive_all_off: assert property (
        s_ctrl_write ##0 (REG_WDATA[CTRL_OPERATING_MODE_FIELD_LSB +: 2] == OPERATING_MODE_FIELD_NONDRIVE)
        |-> ##2 !pu_q && !dppd_q && !dmpd_q && !hs_q
    ) else $error("resistor enable on in non-driving mode");

    a_hsterm_select: assert property (
        operating_mode_field_q != OPERATING_MODE_FIELD_NONDRIVE |=>
        hs_q == ($past(transceiver_speed_select_q) == XCVR_HS &&
                 !$past(termination_select_q))
    ) else $error("high-speed termination does not match selects");

    a_hsterm_write: assert property (
        s_ctrl_write ##0 (REG_WDATA == 8'h00) |-> ##2 hs_q && !pu_q
    ) else $error("termination not on two cycles after high-speed write");

    a_pullup_select: assert property (
        operating_mode_field_q != OPERATING_MODE_FIELD_NONDRIVE |=>
        pu_q == ($past(termination_select_q) &&
                 !$past(dplus_pulldown_bit_q))
    ) else $error("pull-up does not match termination select");

    a_pullup_write: assert property (
        s_ctrl_write ##0 (REG_WDATA == 8'h05) |-> ##2 pu_q[*3]
    ) else $error("pull-up not held after full-speed peripheral write");

    a_pulldown_follow: assert property (
        operating_mode_field_q != OPERATING_MODE_FIELD_NONDRIVE |=>
        dppd_q == $past(dplus_pulldown_bit_q) &&
        dmpd_q == $past(dminus_pulldown_bit_q)
    ) else $error("pull-down enables do not follow their bits");

    a_pulldown_host: assert property (
        s_ctrl_write ##0 (REG_WDATA == 8'h61) |-> ##2 dppd_q && dmpd_q
    ) else $error("host pull-downs not both on");

    a_pulldown_otg: assert property (
        s_ctrl_write ##0 (REG_WDATA == 8'h45) |-> ##2 !dppd_q && dmpd_q && pu_q
    ) else $error("otg peripheral pull-downs wrong");

    a_clock_kept: assert property (
        s_in_uart ##0 clock_keepalive_bit_q |-> INTERFACE_CLOCK_RUN
    ) else $error("clock stopped in UART mode with keep-alive set");

    a_clock_stopped: assert property (
        s_in_uart ##0 !clock_keepalive_bit_q |-> !INTERFACE_CLOCK_RUN
    ) else $error("clock running in UART mode without keep-alive");

    a_uart_exit: assert property (
        s_exit_seen |=> !UART_MODE_ACTIVE && INTERFACE_CLOCK_RUN
    ) else $error("UART mode not left after exit request");

    a_uart_entry: assert property (
        (state_q == BUS_SYNC) && enter_req && !ULPI_STP && !cs_toggle
        |=> UART_MODE_ACTIVE
    ) else $error("UART mode not entered");

    a_reset_state: assert property (
        disable iff (1'b0)
        RESET |=> transceiver_speed_select_q == XCVR_RST &&
        !termination_select_q && operating_mode_field_q == OPERATING_MODE_FIELD_RST &&
        dppd_q && dmpd_q && !pu_q && !hs_q && !UART_MODE_ACTIVE
    ) else $error("power-up state not held after reset");

    a_read_ctrl: assert property (
        REG_RD && (REG_ADDR == CTRL_ADDR) && !REG_WR |=>
        REG_RDATA == $past(ctrl_rd)
    ) else $error("control read data wrong");

endmodule

// File: verification/utd_link_model.sv
// Purpose: Link controller model that programs the decoder and drives pins.
// Assumes: One clock; every signal changes just after a rising edge.
// Notes: Qualified lines are inverted once released, so a stray sample shows.
`timescale 1ns/10ps
module utd_link_model
    import utd_pkg::*;
(
    // Clock
    input wire logic clk,
    // Register port
    output logic [ADDR_W-1:0] addr,
    output logic [DATA_W-1:0] wdata,
    output logic wr,
    output logic rd,
    input wire logic [DATA_W-1:0] rdata,
    // Link control pins
    output logic stp,
    output logic cs_n
);
    initial begin
        addr = '0;
        wdata = '0;
        wr = 1'b0;
        rd = 1'b0;
        stp = 1'b0;
        cs_n = CS_RST;
    end

    // ********************************
    // Register cycles
    // ********************************
    // The link alone picks every control setting
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        addr <= ~a;
        wdata <= ~d;
    endtask

    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        addr <= ~a;
        #1;
        d = rdata;
    endtask

    // ********************************
    // Mode exit pins
    // ********************************
    task automatic set_stp(input logic v);
        @(posedge clk);
        stp <= v;
    endtask

    task automatic cs_toggle;
        @(posedge clk);
        cs_n <= ~cs_n;
    endtask
endmodule

// File: verification/usb_termination_state_decoder_test.sv
// Purpose: Self-checking bench for the termination decoder top.
// Assumes: Link model owns the register port and the exit pins.
// Notes: Rows hold control byte (high) and expected status byte (low).
`timescale 1ns/10ps
module usb_termination_state_decoder_test
    import utd_pkg::*;
;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [7:0] addr, wdata, rdata, got;
    logic wr, rd, stp, cs_n;
    logic pu, dppd, dmpd, hs, clk_run, uart;
    int error_cnt = 0;
    int n_compared = 0;

    // Signalling states: 3-state, host, peripheral, OTG, mode 11, odd mixes
    // Last two rows: power-up host pull-downs, OTG full-speed peripheral
    localparam logic [15:0] ROWS [17] = '{
        16'h6810, 16'h4d10, 16'h701e, 16'h601e, 16'h6516,
        16'h6716, 16'h7616, 16'h1411, 16'h0018, 16'h0511,
        16'h1018, 16'h5415, 16'h401c, 16'h7d16, 16'h2512,
        16'h6116, 16'h4515};

    always #4 clk = ~clk;

    utd_link_model link_u (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .stp(stp), .cs_n(cs_n));

    utd_top dut_u (.CLK_SYS(clk), .RESET(reset), .REG_ADDR(addr),
        .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata),
        .ULPI_STP(stp), .CHIP_SELECT_N(cs_n), .DPLUS_PULLUP_ENABLE(pu),
        .DPLUS_PULLDOWN_ENABLE(dppd), .DMINUS_PULLDOWN_ENABLE(dmpd),
        .HIGHSPEED_TERMINATION_ENABLE(hs), .INTERFACE_CLOCK_RUN(clk_run),
        .UART_MODE_ACTIVE(uart));

    // ********************************
    // Checking and verdict
    // ********************************
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        n_compared++;
        if (g !== e) begin
            error_cnt++;
            $display("Error t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic report_and_stop;
        $display("Compared %0d, mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Pins as one byte: mode, clock run, hs, D- pd, D+ pd, pull-up
    function automatic logic [7:0] pins();
        return {2'h0, uart, clk_run, hs, dmpd, dppd, pu};
    endfunction

    initial begin
        repeat (5000) @(posedge clk);
        error_cnt++;
        report_and_stop();
    end

    // ********************************
    // Main sequence
    // ********************************
    initial begin
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        #1 chk(pins(), 8'h16);
        link_u.rd_reg(CTRL_ADDR, got);
        chk(got, 8'h61);
        link_u.rd_reg(UART_ADDR, got);
        chk(got, 8'h00);
        link_u.wr_reg(8'h03, 8'hff);
        link_u.rd_reg(8'h03, got);
        chk(got, 8'h00);
        link_u.rd_reg(CTRL_ADDR, got);
        chk(got, 8'h61);
        for (int i = 0; i < 17; i++) begin
            link_u.wr_reg(CTRL_ADDR, ROWS[i][15:8]);
            link_u.rd_reg(STAT_ADDR, got);
            chk(got, ROWS[i][7:0]);
            chk(pins(), ROWS[i][7:0]);
            link_u.rd_reg(CTRL_ADDR, got);
            chk(got, ROWS[i][15:8]);
        end
        // Transparent mode with the clock kept alive, left by stop.
        // Termination select is 0 here, so the pull-up stays off.
        link_u.wr_reg(CTRL_ADDR, 8'h01);
        link_u.wr_reg(UART_ADDR, 8'h03);
        #1 chk(pins(), 8'h30);
        link_u.rd_reg(UART_ADDR, got);
        chk(got, 8'h05);
        link_u.set_stp(1'b1);
        link_u.set_stp(1'b0);
        #1 chk(pins(), 8'h10);
        // Default keep-alive stops the clock; a chip select change exits
        link_u.wr_reg(UART_ADDR, 8'h02);
        #1 chk(pins(), 8'h20);
        link_u.cs_toggle();
        @(posedge clk);
        #1 chk(pins(), 8'h10);
        // Entry is refused while stop is held high
        link_u.set_stp(1'b1);
        link_u.wr_reg(UART_ADDR, 8'h03);
        #1 chk(pins(), 8'h10);
        link_u.set_stp(1'b0);
        // Reset in mid-run restores the power-up state
        link_u.wr_reg(CTRL_ADDR, 8'h14);
        @(posedge clk);
        reset <= 1'b1;
        @(posedge clk);
        reset <= 1'b0;
        #1 chk(pins(), 8'h16);
        // Keep-alive was left at 1 above; reset must clear it
        link_u.rd_reg(UART_ADDR, got);
        chk(got, 8'h00);
        link_u.rd_reg(CTRL_ADDR, got);
        chk(got, 8'h61);
        report_and_stop();
    end
endmodule
